/* File: pkg/pmcc_pkg.sv */
// pmcc_pkg: register map, field layout and timing constants of the
// pll / master clock control block.
// assumes a 32-bit classic wishbone slave port and a 25 MHz system clock.
package pmcc_pkg;

  // register byte offsets
  localparam logic [7:0] PMCC_OFS_PLL_CONFIG  = 8'h2C;
  localparam logic [7:0] PMCC_OFS_MCK_CONFIG  = 8'h30;
  localparam logic [7:0] PMCC_OFS_AUX0_CONFIG = 8'h40;
  localparam logic [7:0] PMCC_OFS_IRQ_SET     = 8'h60;
  localparam logic [7:0] PMCC_OFS_IRQ_CLEAR   = 8'h64;
  localparam logic [7:0] PMCC_OFS_STATUS      = 8'h68;
  localparam logic [7:0] PMCC_OFS_IRQ_MASK    = 8'h6C;
  localparam logic [7:0] PMCC_OFS_OSC_CONTROL = 8'h20;
  localparam logic [7:0] PMCC_OFS_OSC_FREQ    = 8'h24;

  localparam int PMCC_AUX_COUNT = 3;

  // pll_config fields
  localparam int PMCC_PLL_DIV_LSB  = 0;
  localparam int PMCC_PLL_CNT_LSB  = 8;
  localparam int PMCC_PLL_OUT_LSB  = 14;
  localparam int PMCC_PLL_MUL_LSB  = 16;
  localparam int PMCC_PLL_USB_LSB  = 28;
  localparam logic [31:0] PMCC_PLL_MASK = 32'h37FF_FFFF;

  // source and scale fields of master and aux configs
  localparam int PMCC_SRC_LSB   = 0;
  localparam int PMCC_SCALE_LSB = 2;
  localparam logic [31:0] PMCC_CKSEL_MASK = 32'h0000_001F;

  // event bit layout shared by set, clear, status and mask
  localparam int PMCC_EV_OSC  = 0;
  localparam int PMCC_EV_LOCK = 2;
  localparam int PMCC_EV_MCK  = 3;
  localparam int PMCC_EV_AUX0 = 8;
  localparam logic [31:0] PMCC_EV_MASK = 32'h0000_070D;

  // osc frequency register layout
  localparam int PMCC_FREQ_VALID_BIT = 16;
  localparam int PMCC_FREQ_WINDOW    = 16;

  // osc control: enable bit and startup count
  localparam int PMCC_OSC_EN_BIT  = 0;
  localparam int PMCC_OSC_CNT_LSB = 8;
  localparam int PMCC_OSC_CNT_MUL = 8;

  // ready settle time, in clk cycles
  localparam int PMCC_CLK_MHZ       = 25;
  localparam int PMCC_SETTLE_NS     = 200;
  localparam int PMCC_SETTLE_CYCLES = (PMCC_SETTLE_NS * PMCC_CLK_MHZ + 999)
                                      / 1000;

  localparam logic [31:0] PMCC_RESET_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PMCC_SRC_SLOW = 2'b00,
    PMCC_SRC_MAIN = 2'b01,
    PMCC_SRC_RSVD = 2'b10,
    PMCC_SRC_PLL  = 2'b11
  } pmcc_src_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } pmcc_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pmcc_wb_rsp_type;

endpackage : pmcc_pkg

/* File: rtl/pmcc_clock_gate.sv */
// pmcc_clock_gate: one selected, prescaled clock enable with a ready flag.
// assumes source ticks are one-cycle pulses in the clk domain.
`timescale 1ns/1ns
`default_nettype none
module pmcc_clock_gate (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // source ticks
  input  wire logic       slowTick,
  input  wire logic       mainTick,
  input  wire logic       pllTick,
  // configuration
  input  wire logic [1:0] sourceSelect,
  input  wire logic [2:0] scaleSelect,
  input  wire logic       configWrite,
  // outputs
  output logic            clockTick,
  output logic            ready
);
  import pmcc_pkg::*;

  logic       srcTick;
  logic [5:0] prescale;
  logic [5:0] scaleMax;
  logic [7:0] settle;

  always_comb begin
    case (pmcc_src_type'(sourceSelect))
      PMCC_SRC_SLOW: srcTick = slowTick;
      PMCC_SRC_MAIN: srcTick = mainTick;
      PMCC_SRC_PLL:  srcTick = pllTick;
      default:       srcTick = 1'b0;
    endcase
  end

  // divide by 2**scale; reserved code 111 stops the clock
  assign scaleMax = (scaleSelect == 3'b111) ? 6'h00
                  : 6'((7'h01 << scaleSelect) - 7'h01);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prescale  <= 6'h00;
      clockTick <= 1'b0;
    end else begin
      clockTick <= 1'b0;
      if (configWrite) begin
        prescale <= 6'h00;
      end else if (srcTick && scaleSelect != 3'b111) begin
        if (prescale >= scaleMax) begin
          prescale  <= 6'h00;
          clockTick <= 1'b1;
        end else begin
          prescale <= prescale + 6'h01;
        end
      end
    end
  end

  // ready drops on a config write and returns once settled, unless source 10 or scale 111 is selected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settle <= 8'h00;
      ready  <= 1'b0;
    end else if (configWrite) begin
      settle <= 8'(PMCC_SETTLE_CYCLES);
      ready  <= 1'b0;
    end else if (settle != 8'h00) begin
      settle <= settle - 8'h01;
    end else begin
      ready <= (sourceSelect != 2'b10) && (scaleSelect != 3'b111);
    end
  end

endmodule : pmcc_clock_gate
`default_nettype wire

/* File: rtl/pmcc_clock_control.sv */
// pmcc_clock_control: pll configuration, master clock and aux clock
// selection, event status and interrupt enables behind a wishbone slave.
// assumes slow and main oscillator clocks arrive as one-cycle tick pulses
// synchronous to clk (25 MHz, far faster than either).
//
// Functional notes
// R1: frequency count valid reads 1 only when oscillator on and count done.
// R2: input ratio 0 gives no clock, 1 passes through, 2..255 divides.
// R3: after a pll_config write, count settle slow cycles before lock.
// R4: feedback factor 0 stops pll; otherwise output is input times factor+1.
// R5: usb ratio 00 passes, 01 halves, 10 quarters, 11 reserved.
// R6: software must program output range to match pll frequency.
// R7: master source 00 slow, 01 main, 11 pll, 10 reserved.
// R8: master scale 000..110 divides by 1 to 64; 111 reserved.
// R9: each aux output selects slow, main or pll the same way.
// R10: each aux output divides by 1 to 64 per its scale code.
// R11: writing 1 to enable-set bits enables; 0 leaves unchanged.
// R12: writing 1 to enable-clear bits disables; 0 leaves unchanged.
// R13: event bits: osc 0, lock 2, master 3, aux 8 to 10.
// R14: osc stable flag reads 1 once oscillator has stabilized.
// R15: lock flag reads 1 when pll is locked.
// R16: master ready flag reads 1 when master clock is ready.
// R17: each aux ready flag reads 1 when its output is ready.
// R18: mask view shows 0 for enabled source, 1 for disabled.
// R19: frequency count holds main cycles within 16 slow periods.
// R20: interrupt output high while any enabled status flag is set.
// R21: pll_config write clears lock before settle counting starts.
`timescale 1ns/1ns
`default_nettype none
module pmcc_clock_control (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // wishbone slave
  input  wire pmcc_pkg::pmcc_wb_req_type wbReq,
  output pmcc_pkg::pmcc_wb_rsp_type      wbRsp,
  // oscillator ticks
  input  wire logic                      slowTick,
  input  wire logic                      mainTick,
  // generated clock enables
  output logic                           pllTick,
  output logic                           usbTick,
  output logic                           masterTick,
  output logic [2:0]                     auxTick,
  // interrupt
  output logic                           pmcIrq
);
  import pmcc_pkg::*;

  logic [31:0] pllConfig;
  logic [31:0] masterConfig;
  logic [31:0] auxConfig [PMCC_AUX_COUNT];
  logic [31:0] oscControl;
  logic [31:0] irqEnable;
  logic [31:0] status;
  logic [5:0]  pllSettle;
  logic        pllLocked;
  logic        oscStable;
  logic [15:0] oscWait;
  logic [15:0] freqCount;
  logic [15:0] freqRun;
  logic [4:0]  freqSlow;
  logic        freqValid;
  logic [7:0]  divCount;
  logic        divTick;
  logic [10:0] mulCount;
  logic [1:0]  usbCount;
  logic        masterReady;
  logic [2:0]  auxReady;
  logic [2:0]  auxWrite;
  logic        masterWrite;
  logic        wbHit;
  logic        wbWrite;
  logic [31:0] wbData;
  logic [31:0] next_rdata;

  logic [7:0]  pllDiv;
  logic [10:0] pllMul;
  logic [1:0]  pllUsb;
  assign pllDiv = pllConfig[PMCC_PLL_DIV_LSB +: 8];
  assign pllMul = pllConfig[PMCC_PLL_MUL_LSB +: 11];
  assign pllUsb = pllConfig[PMCC_PLL_USB_LSB +: 2];

  // single-cycle ack; writes take effect at the acked edge
  assign wbHit   = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  assign wbWrite = wbHit && wbReq.we;
  always_comb begin
    wbData = wbReq.dat;
    for (int i = 0; i < 4; i++) begin
      if (!wbReq.sel[i]) begin
        wbData[8*i +: 8] = 8'h00;
      end
    end
  end

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  logic pllWrite;
  assign pllWrite    = wbWrite && wbReq.adr == PMCC_OFS_PLL_CONFIG;
  assign masterWrite = wbWrite && wbReq.adr == PMCC_OFS_MCK_CONFIG;

  // the range field is only stored; choosing the band
  // is left to software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pllConfig <= PMCC_RESET_ZERO;
    end else if (pllWrite) begin
      pllConfig <= mergeBytes(pllConfig, wbReq.dat, wbReq.sel)
                   & PMCC_PLL_MASK; // R6
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      masterConfig <= PMCC_RESET_ZERO;
    end else if (masterWrite) begin
      masterConfig <= mergeBytes(masterConfig, wbReq.dat, wbReq.sel)
                      & PMCC_CKSEL_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscControl <= PMCC_RESET_ZERO;
    end else if (wbWrite && wbReq.adr == PMCC_OFS_OSC_CONTROL) begin
      oscControl <= mergeBytes(oscControl, wbReq.dat, wbReq.sel)
                    & 32'h0000_FF01;
    end
  end

  generate
    for (genvar g = 0; g < PMCC_AUX_COUNT; g++) begin : gAux
      assign auxWrite[g] = wbWrite
        && wbReq.adr == PMCC_OFS_AUX0_CONFIG + 8'(4 * g);
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          auxConfig[g] <= PMCC_RESET_ZERO;
        end else if (auxWrite[g]) begin
          auxConfig[g] <= mergeBytes(auxConfig[g], wbReq.dat, wbReq.sel)
                          & PMCC_CKSEL_MASK;
        end
      end
      pmcc_clock_gate uAuxGate (
        .clk          (clk),
        .resetn       (resetn),
        .slowTick     (slowTick),
        .mainTick     (mainTick),
        .pllTick      (pllTick),
        .sourceSelect (auxConfig[g][PMCC_SRC_LSB +: 2]),   // R9
        .scaleSelect  (auxConfig[g][PMCC_SCALE_LSB +: 3]), // R10
        .configWrite  (auxWrite[g]),
        .clockTick    (auxTick[g]),
        .ready        (auxReady[g])                       // R17
      );
    end
  endgenerate

  pmcc_clock_gate uMasterGate (
    .clk          (clk),
    .resetn       (resetn),
    .slowTick     (slowTick),
    .mainTick     (mainTick),
    .pllTick      (pllTick),
    .sourceSelect (masterConfig[PMCC_SRC_LSB +: 2]),   // R7
    .scaleSelect  (masterConfig[PMCC_SCALE_LSB +: 3]), // R8
    .configWrite  (masterWrite),
    .clockTick    (masterTick),
    .ready        (masterReady)                       // R16
  );

  // interrupt enables: set wins over clear when both hit one bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqEnable <= PMCC_RESET_ZERO;
    end else if (wbWrite && wbReq.adr == PMCC_OFS_IRQ_SET) begin
      irqEnable <= irqEnable | (wbData & PMCC_EV_MASK); // R11
    end else if (wbWrite && wbReq.adr == PMCC_OFS_IRQ_CLEAR) begin
      irqEnable <= irqEnable & ~(wbData & PMCC_EV_MASK); // R12
    end
  end

  // oscillator startup: enable bit, count in units of 8 slow cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscWait   <= 16'h0000;
      oscStable <= 1'b0;
    end else if (!oscControl[PMCC_OSC_EN_BIT]) begin
      oscWait   <= 16'h0000;
      oscStable <= 1'b0;
    end else if (!oscStable && slowTick) begin
      if (oscWait >= 16'(oscControl[PMCC_OSC_CNT_LSB +: 8]
                         * PMCC_OSC_CNT_MUL)) begin
        oscStable <= 1'b1; // R14
      end else begin
        oscWait <= oscWait + 16'h0001;
      end
    end
  end

  // frequency measurement over 16 slow periods after the osc is stable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freqRun   <= 16'h0000;
      freqSlow  <= 5'h00;
      freqCount <= 16'h0000;
      freqValid <= 1'b0;
    end else if (!oscStable) begin
      freqRun   <= 16'h0000;
      freqSlow  <= 5'h00;
      freqValid <= 1'b0; // R1
    end else if (!freqValid) begin
      if (freqSlow == 5'(PMCC_FREQ_WINDOW) && slowTick) begin
        freqCount <= freqRun; // R19
        freqValid <= 1'b1;    // R1
      end else begin
        if (slowTick) begin
          freqSlow <= freqSlow + 5'h01;
        end
        if (mainTick && freqSlow != 5'h00) begin
          freqRun <= freqRun + 16'h0001;
        end
      end
    end
  end

  // input divider: 0 stops, 1 bypasses, n divides by n
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCount <= 8'h00;
      divTick  <= 1'b0;
    end else begin
      divTick <= 1'b0;
      if (pllWrite || pllDiv == 8'h00) begin
        divCount <= 8'h00; // R2
      end else if (mainTick) begin
        if (divCount >= pllDiv - 8'h01) begin
          divCount <= 8'h00;
          divTick  <= 1'b1; // R2
        end else begin
          divCount <= divCount + 8'h01;
        end
      end
    end
  end

  // pll model: factor+1 output ticks per input tick, spread over the
  // following clk cycles; factor 0 stops it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mulCount <= 11'h000;
      pllTick  <= 1'b0;
    end else if (pllMul == 11'h000 || !pllLocked) begin
      mulCount <= 11'h000; // R4
      pllTick  <= 1'b0;
    end else if (divTick) begin
      mulCount <= pllMul; // R4
      pllTick  <= 1'b1;
    end else if (mulCount != 11'h000) begin
      mulCount <= mulCount - 11'h001;
      pllTick  <= 1'b1;
    end else begin
      pllTick <= 1'b0;
    end
  end

  // usb divider off the pll ticks; 11 yields no clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      usbCount <= 2'b00;
      usbTick  <= 1'b0;
    end else begin
      usbTick <= 1'b0;
      if (pllTick && pllUsb != 2'b11) begin
        if (usbCount >= 2'((3'b001 << pllUsb) - 3'b001)) begin
          usbCount <= 2'b00;
          usbTick  <= 1'b1; // R5
        end else begin
          usbCount <= usbCount + 2'b01;
        end
      end
    end
  end

  // lock: cleared by each config write, then wait the settle count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pllSettle <= 6'h00;
      pllLocked <= 1'b0;
    end else if (pllWrite) begin
      pllSettle <= wbData[PMCC_PLL_CNT_LSB +: 6]; // R3
      pllLocked <= 1'b0;                          // R21
    end else if (!pllLocked && pllMul != 11'h000) begin
      if (pllSettle == 6'h00) begin
        pllLocked <= 1'b1; // R15
      end else if (slowTick) begin
        pllSettle <= pllSettle - 6'h01; // R3
      end
    end
  end

  always_comb begin
    status = PMCC_RESET_ZERO;
    status[PMCC_EV_OSC]  = oscStable;
    status[PMCC_EV_LOCK] = pllLocked;
    status[PMCC_EV_MCK]  = masterReady;
    status[PMCC_EV_AUX0 +: PMCC_AUX_COUNT] = auxReady; // R13
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pmcIrq <= 1'b0;
    end else begin
      pmcIrq <= |(status & irqEnable); // R20
    end
  end

  // read mux; unmapped and write-only offsets read as zero
  always_comb begin
    next_rdata = PMCC_RESET_ZERO;
    if (wbReq.adr == PMCC_OFS_PLL_CONFIG) begin
      next_rdata = pllConfig;
    end else if (wbReq.adr == PMCC_OFS_MCK_CONFIG) begin
      next_rdata = masterConfig;
    end else if (wbReq.adr == PMCC_OFS_AUX0_CONFIG) begin
      next_rdata = auxConfig[0];
    end else if (wbReq.adr == PMCC_OFS_AUX0_CONFIG + 8'h04) begin
      next_rdata = auxConfig[1];
    end else if (wbReq.adr == PMCC_OFS_AUX0_CONFIG + 8'h08) begin
      next_rdata = auxConfig[2];
    end else if (wbReq.adr == PMCC_OFS_OSC_CONTROL) begin
      next_rdata = oscControl;
    end else if (wbReq.adr == PMCC_OFS_OSC_FREQ) begin
      next_rdata[15:0] = freqCount;
      next_rdata[PMCC_FREQ_VALID_BIT] = freqValid; // R1
    end else if (wbReq.adr == PMCC_OFS_STATUS) begin
      next_rdata = status;
    end else if (wbReq.adr == PMCC_OFS_IRQ_MASK) begin
      next_rdata = ~irqEnable & PMCC_EV_MASK; // R18
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= wbHit;
      wbRsp.dat <= (wbHit && !wbReq.we) ? next_rdata : PMCC_RESET_ZERO;
    end
  end

endmodule : pmcc_clock_control
`default_nettype wire

/* File: tb/pmcc_clock_control_monitor.sv */
// pmcc_clock_control_monitor: bus, mask view, irq and tick assertions.
// assumes the master always sets all four sel lanes.
`timescale 1ns/1ns
`default_nettype none
module pmcc_clock_control_monitor (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      resetn,
  // bus
  input wire pmcc_pkg::pmcc_wb_req_type wbReq,
  input wire pmcc_pkg::pmcc_wb_rsp_type wbRsp,
  // ticks and interrupt
  input wire logic                      slowTick,
  input wire logic                      mainTick,
  input wire logic                      pllTick,
  input wire logic                      usbTick,
  input wire logic                      masterTick,
  input wire logic [2:0]                auxTick,
  input wire logic                      pmcIrq
);
  import pmcc_pkg::*;
  logic [31:0] irqEnable;
  logic        pllStopped;
  logic        anySource;
  logic        wrTaken;
  logic        rdTaken;

  assign anySource = slowTick | mainTick | pllTick;
  assign wrTaken   = wbRsp.ack & wbReq.we;
  assign rdTaken   = wbRsp.ack & ~wbReq.we;

  // enable shadow, one edge behind the design
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqEnable <= 32'h0000_0000;
    end else if (wrTaken && wbReq.adr == PMCC_OFS_IRQ_SET) begin
      irqEnable <= irqEnable | (wbReq.dat & PMCC_EV_MASK);
    end else if (wrTaken && wbReq.adr == PMCC_OFS_IRQ_CLEAR) begin
      irqEnable <= irqEnable & ~wbReq.dat;
    end
  end

  // factor 0 or ratio 0: pll stays silent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pllStopped <= 1'b0;
    end else if (wrTaken && wbReq.adr == PMCC_OFS_PLL_CONFIG) begin
      pllStopped <= wbReq.dat[26:16] == 11'h000 || wbReq.dat[7:0] == 8'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ack_pulse_a: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack held beyond one cycle");
  ack_answer_a: assert property
    (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
    else $error("request not answered in one cycle");
  idle_zero_a: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0000_0000)
    else $error("read data not zero outside ack");
  reset_quiet_a: assert property ($rose(resetn) |->
    !wbRsp.ack && !pmcIrq && !pllTick && !masterTick && auxTick == 3'h0)
    else $error("outputs active right after reset");
  wo_read_a: assert property (rdTaken && (wbReq.adr == PMCC_OFS_IRQ_SET ||
    wbReq.adr == PMCC_OFS_IRQ_CLEAR) |-> wbRsp.dat == 32'h0000_0000)
    else $error("write-only register read nonzero");
  mask_view_a: assert property (rdTaken && wbReq.adr == PMCC_OFS_IRQ_MASK |->
    wbRsp.dat == (~irqEnable & PMCC_EV_MASK))
    else $error("mask view does not match enables");
  irq_off_a: assert property (wrTaken && wbReq.adr == PMCC_OFS_IRQ_CLEAR &&
    wbReq.dat == PMCC_EV_MASK |=> !pmcIrq [*2])
    else $error("irq still high after all disabled");
  irq_cause_a: assert property (pmcIrq |-> irqEnable != 32'h0000_0000)
    else $error("irq high with no source enabled");
  pll_stop_a: assert property (pllStopped && $past(pllStopped, 8) |-> !pllTick)
    else $error("pll ticks while stopped");
  usb_src_a: assert property (usbTick |-> $past(pllTick) || $past(pllTick, 2))
    else $error("usb tick without pll tick");
  master_src_a: assert property (masterTick |-> $past(anySource) ||
    $past(anySource, 2) || $past(anySource, 3))
    else $error("master tick without source tick");
  aux_src_a: assert property (auxTick != 3'h0 |-> $past(anySource) ||
    $past(anySource, 2) || $past(anySource, 3))
    else $error("aux tick without source tick");

  cover property (pmcIrq);
  cover property (usbTick);
  cover property (auxTick[2]);
endmodule : pmcc_clock_control_monitor

bind pmcc_clock_control pmcc_clock_control_monitor
  i_pmcc_clock_control_monitor (
  .clk(clk), .resetn(resetn), .wbReq(wbReq), .wbRsp(wbRsp),
  .slowTick(slowTick), .mainTick(mainTick), .pllTick(pllTick),
  .usbTick(usbTick), .masterTick(masterTick), .auxTick(auxTick),
  .pmcIrq(pmcIrq));
`default_nettype wire

/* File: tb/test_pmcc_clock_control.sv */
// test_pmcc_clock_control: register table, tick rates, lock, irq, osc.
// assumes main ticks every 8 clocks and slow ticks every 64 clocks.
`timescale 1ns/1ns
`default_nettype none
module test_pmcc_clock_control;
  import pmcc_pkg::*;
  typedef struct packed {
    logic        we;
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [31:0] exp;
  } pmcc_row_type;
  localparam logic [31:0] NIL = 32'h0000_0000;
  localparam pmcc_row_type ROWS [17] = '{
    '{1'b1, PMCC_OFS_MCK_CONFIG, 32'h0000_0019, NIL},
    '{1'b0, PMCC_OFS_MCK_CONFIG, NIL, 32'h0000_0019},
    '{1'b1, PMCC_OFS_AUX0_CONFIG, 32'h0000_0013, NIL},
    '{1'b1, 8'h44, 32'h0000_0016, NIL},
    '{1'b1, 8'h48, 32'hFFFF_FFFF, NIL},
    '{1'b0, PMCC_OFS_AUX0_CONFIG, NIL, 32'h0000_0013},
    '{1'b0, 8'h44, NIL, 32'h0000_0016},
    '{1'b0, 8'h48, NIL, 32'h0000_001F},
    '{1'b1, PMCC_OFS_PLL_CONFIG, 32'hFFFF_FFFF, NIL},
    '{1'b0, PMCC_OFS_PLL_CONFIG, NIL, 32'h37FF_FFFF},
    '{1'b1, PMCC_OFS_IRQ_SET, 32'h0000_0109, NIL},
    '{1'b0, PMCC_OFS_IRQ_MASK, NIL, 32'h0000_0604},
    '{1'b1, PMCC_OFS_IRQ_CLEAR, 32'h0000_0001, NIL},
    '{1'b0, PMCC_OFS_IRQ_MASK, NIL, 32'h0000_0605},
    '{1'b0, PMCC_OFS_IRQ_SET, NIL, NIL},
    '{1'b1, 8'hF0, 32'hFFFF_FFFF, NIL},
    '{1'b0, 8'hF0, NIL, NIL}};
  localparam logic [7:0] DIVS [6] = '{8'h01, 8'h02, 8'h00, 8'h01, 8'h01, 8'h01};
  localparam logic [10:0] FACS [6] = '{11'h003, 11'h003, 11'h003, 11'h000,
                                       11'h003, 11'h003};
  localparam logic [1:0] USBS [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
  localparam int PLLX [6] = '{160, 80, 0, 0, 160, 160};
  localparam int USBX [6] = '{160, 80, 0, 0, 80, 40};

  logic            clk;
  logic            resetn;
  pmcc_wb_req_type wbReq;
  pmcc_wb_rsp_type wbRsp;
  logic            slowTick;
  logic            mainTick;
  logic            pllTick;
  logic            usbTick;
  logic            masterTick;
  logic [2:0]      auxTick;
  logic            pmcIrq;
  logic [5:0]      ticks;
  logic [31:0]     rdData;
  int              phase;
  int              tickCount [6];
  int              tickBase [6];
  int              mismatches;
  int              checksDone;

  pmcc_clock_control i_pmcc_clock_control (
    .clk(clk), .resetn(resetn), .wbReq(wbReq), .wbRsp(wbRsp),
    .slowTick(slowTick), .mainTick(mainTick), .pllTick(pllTick),
    .usbTick(usbTick), .masterTick(masterTick), .auxTick(auxTick),
    .pmcIrq(pmcIrq));

  assign ticks = {auxTick, masterTick, usbTick, pllTick};
  always #20 clk = ~clk;
  // non-blocking, so reads right after an edge are stable
  always @(posedge clk) begin
    phase    <= phase + 1;
    mainTick <= phase % 8 == 0;
    slowTick <= phase % 64 == 3;
    for (int k = 0; k < 6; k++) begin
      tickCount[k] <= tickCount[k] + int'(ticks[k]);
    end
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic expect_word(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : expect_word

  // window alignment costs a tick or two
  task automatic expect_near(input int got, input int exp);
    checksDone++;
    if (got > exp + 2 || got < exp - 2) begin
      mismatches++;
      $display("wrong value at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask : expect_near

  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
    int n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    do begin
      @(posedge clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    rdData = wbRsp.dat;
    wbReq <= '0;
    @(posedge clk);
    if (n >= 20) begin
      mismatches++;
      $display("wrong value at %0t: no bus answer", $time);
    end
  endtask : xfer

  task automatic rd(input logic [7:0] adr, input logic [31:0] msk,
                    input logic [31:0] exp);
    xfer(1'b0, adr, NIL);
    expect_word(rdData & msk, exp);
  endtask : rd

  task automatic window(input int lead);
    repeat (lead) @(posedge clk);
    tickBase = tickCount;
    repeat (320) @(posedge clk);
  endtask : window

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    wbReq = '0;
    slowTick = 1'b0;
    mainTick = 1'b0;
    phase = 0;
    tickCount = '{default: 0};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(PMCC_OFS_IRQ_MASK, 32'hFFFF_FFFF, PMCC_EV_MASK);
    rd(PMCC_OFS_OSC_FREQ, 32'h0001_0000, NIL);
    foreach (ROWS[r]) begin
      xfer(ROWS[r].we, ROWS[r].adr, ROWS[r].dat);
      if (!ROWS[r].we) expect_word(rdData, ROWS[r].exp);
    end
    xfer(1'b1, PMCC_OFS_IRQ_CLEAR, PMCC_EV_MASK);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, PMCC_OFS_PLL_CONFIG,
           {2'b00, USBS[i], 1'b0, FACS[i], 8'h01, DIVS[i]});
      window(200);
      expect_near(tickCount[0] - tickBase[0], PLLX[i]);
      expect_near(tickCount[1] - tickBase[1], USBX[i]);
    end
    for (int s = 0; s < 7; s++) begin
      xfer(1'b1, PMCC_OFS_MCK_CONFIG, (32'(s) << 2) | 32'h0000_0003);
      window(20);
      expect_near(tickCount[2] - tickBase[2], 160 >> s);
    end
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, PMCC_OFS_AUX0_CONFIG + 8'(4 * k),
           (32'(k) << 2) | 32'h0000_0001);
      window(20);
      expect_near(tickCount[3 + k] - tickBase[3 + k], 40 >> k);
    end
    rd(PMCC_OFS_STATUS, 32'h0000_0700, 32'h0000_0700);
    xfer(1'b1, PMCC_OFS_MCK_CONFIG, 32'h0000_0002);
    window(20);
    expect_near(tickCount[2] - tickBase[2], 0);
    rd(PMCC_OFS_STATUS, 32'h0000_0008, NIL);
    xfer(1'b1, PMCC_OFS_MCK_CONFIG, 32'h0000_0001);
    rd(PMCC_OFS_STATUS, 32'h0000_0008, NIL);
    repeat (10) @(posedge clk);
    rd(PMCC_OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    xfer(1'b1, PMCC_OFS_IRQ_SET, 32'h0000_0004);
    xfer(1'b1, PMCC_OFS_PLL_CONFIG, 32'h0003_0401);
    rd(PMCC_OFS_STATUS, 32'h0000_0004, NIL);
    expect_word(32'(pmcIrq), NIL);
    repeat (120) @(posedge clk);
    rd(PMCC_OFS_STATUS, 32'h0000_0004, NIL);
    repeat (300) @(posedge clk);
    rd(PMCC_OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
    expect_word(32'(pmcIrq), 32'h0000_0001);
    xfer(1'b1, PMCC_OFS_IRQ_CLEAR, PMCC_EV_MASK);
    repeat (2) @(posedge clk);
    expect_word(32'(pmcIrq), NIL);
    xfer(1'b1, PMCC_OFS_OSC_CONTROL, 32'h0000_0101);
    repeat (2000) @(posedge clk);
    rd(PMCC_OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    rd(PMCC_OFS_OSC_FREQ, 32'h0001_0000, 32'h0001_0000);
    expect_near(int'(rdData[15:0]), 128);
    xfer(1'b1, PMCC_OFS_OSC_CONTROL, NIL);
    repeat (4) @(posedge clk);
    rd(PMCC_OFS_STATUS, 32'h0000_0001, NIL);
    rd(PMCC_OFS_OSC_FREQ, 32'h0001_0000, NIL);
    xfer(1'b1, PMCC_OFS_IRQ_SET, PMCC_EV_MASK);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(PMCC_OFS_IRQ_MASK, 32'hFFFF_FFFF, PMCC_EV_MASK);
    tally_and_finish();
  end

  // about 9500 cycles are needed; more means a hang
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : test_pmcc_clock_control
`default_nettype wire
